// >>> pavc_core.sv
// Position actual value conditioning core
`default_nettype none
module pavc_core
  import pavc_pkg::*;
#(
  parameter int VEL_WIN = VEL_WIN_CYC
) (
  input  wire logic                      mclk_in,
  input  wire logic                      rstn_in,
  input  wire logic [NUM_ENC*ENC_W-1:0]  encoder_cyclic_position_in,
  input  wire logic [NUM_ENC-1:0]        encoder_valid_in,
  input  wire logic [NUM_ENC*CTL_W-1:0]  generated_encoder_control_word_in,
  input  wire logic [pavc_pkg::SEL_W-1:0] encoder_assignment_in,
  input  wire logic                      encoder_linear_in,
  input  wire logic [15:0]               encoder_pulses_per_rev_in,
  input  wire logic [4:0]                fine_resolution_bits_in,
  input  wire logic                      measuring_gear_type_in,
  input  wire logic [GEAR_W-1:0]         measuring_gear_encoder_revs_in,
  input  wire logic [GEAR_W-1:0]         measuring_gear_load_revs_in,
  input  wire logic [GEAR_W-1:0]         motor_revolutions_in,
  input  wire logic signed [GEAR_W-1:0]  load_revolutions_in,
  input  wire logic [POS_W-1:0]          length_units_per_load_rev_in,
  input  wire logic [POS_W-1:0]          length_units_per_10mm_in,
  input  wire logic [POS_W-1:0]          encoder_counts_per_10mm_in,
  input  wire logic                      basic_positioner_active_in,
  input  wire logic                      correction_activate_in,
  input  wire logic signed [POS_W-1:0]   correction_value_in,
  input  wire logic                      positioner_correction_activate_in,
  input  wire logic signed [POS_W-1:0]   positioner_correction_value_in,
  input  wire logic signed [POS_W-1:0]   position_offset_input_in,
  input  wire logic signed [POS_W-1:0]   positioner_backlash_offset_in,
  input  wire logic                      set_position_request_in,
  input  wire logic signed [POS_W-1:0]   position_setting_value_in,
  output logic [NUM_ENC*CTL_W-1:0]       encoder_control_input_out,
  output logic signed [POS_W-1:0]        position_actual_value_out,
  output logic signed [POS_W-1:0]        velocity_actual_value_out,
  output logic                           position_valid_out
);
  import pavc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Channel selection
  logic signed [ENC_W-1:0] enc_pos [NUM_ENC];
  logic [NUM_ENC*CTL_W-1:0] ctl_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ENC; gi++) begin : g_ch
      assign enc_pos[gi] = encoder_cyclic_position_in[gi*ENC_W +: ENC_W];
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) ctl_q <= '0;
    else          ctl_q <= generated_encoder_control_word_in;
  end
  assign encoder_control_input_out = ctl_q;

  // channel select, out-of-range picks channel 0
  wire [SEL_W-1:0] sel_idx = (encoder_assignment_in == 2'h1) ? 2'h1 :
                             (encoder_assignment_in == 2'h2) ? 2'h2 : 2'h0;
  wire signed [ENC_W-1:0] raw_pos = enc_pos[sel_idx];
  wire                    raw_ok  = encoder_valid_in[sel_idx];

  ////////////////////////////////////////////////////////////////////////////////
  // Scaling; increments are taken as deltas so scaled errors do not accumulate
  logic signed [ENC_W-1:0] prev_raw_q;
  logic                    have_prev_q;
  logic [SEL_W-1:0]        prev_sel_q;
  wire signed [ENC_W-1:0]  d_inc = raw_pos - prev_raw_q;

  wire [47:0] res_base = {32'h0, encoder_pulses_per_rev_in} << fine_resolution_bits_in;
  // Measuring gear: encoder revolutions scale the numerator, load revolutions the denominator
  wire [GEAR_W-1:0] gear_mul = measuring_gear_type_in ? measuring_gear_encoder_revs_in
                                                      : GEAR_W'(1);
  wire [63:0] res_load_rev = measuring_gear_type_in ?
                         64'(res_base) * 64'(measuring_gear_load_revs_in) : 64'(res_base);

  // rotary: delta * LU/rev * load / (res * motor)
  // signed load revolutions flip the sign
  wire signed [95:0] rot_num = 96'(signed'(d_inc)) *
                               96'(signed'({1'b0, length_units_per_load_rev_in})) *
                               96'(load_revolutions_in) *
                               96'(signed'({1'b0, gear_mul}));
  wire signed [95:0] rot_den = 96'(signed'({1'b0, res_load_rev})) *
                               96'(signed'({1'b0, motor_revolutions_in}));
  // linear: delta * LU per 10 mm / counts per 10 mm
  wire signed [95:0] lin_num = 96'(signed'(d_inc)) *
                               96'(signed'({1'b0, length_units_per_10mm_in}));
  wire signed [95:0] lin_den = 96'(signed'({1'b0, encoder_counts_per_10mm_in}));
  wire signed [95:0] num = encoder_linear_in ? lin_num : rot_num;
  wire signed [95:0] den = encoder_linear_in ? lin_den : rot_den;
  // Remainder is carried so slow motion is never lost in truncation
  logic signed [95:0] rem_q;
  wire signed [95:0] num_r  = num + rem_q;
  wire               den_ok = (den != 96'sh0);
  wire signed [95:0] quo    = den_ok ? num_r / den : 96'sh0;
  wire signed [95:0] rem_d  = den_ok ? num_r - quo * den : 96'sh0;
  wire signed [POS_W-1:0] d_lu = quo[POS_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Correction, offset and set-position
  // positioner takes over the correction source
  wire                    corr_act = basic_positioner_active_in ?
                                     positioner_correction_activate_in : correction_activate_in;
  wire signed [POS_W-1:0] corr_val = basic_positioner_active_in ?
                                     positioner_correction_value_in : correction_value_in;
  wire signed [POS_W-1:0] offs     = basic_positioner_active_in ?
                                     positioner_backlash_offset_in : position_offset_input_in;
  logic corr_prev_q;
  wire  corr_edge = corr_act & ~corr_prev_q;

  pavc_state_t state_q;
  logic signed [POS_W-1:0] base_q;
  logic signed [POS_W-1:0] pos_q;

  wire tracking = (state_q == PAVC_ST_TRACK) && have_prev_q && (prev_sel_q == sel_idx) && raw_ok;
  wire signed [POS_W-1:0] base_d = corr_edge ? base_q + (tracking ? d_lu : '0) + corr_val
                                             : base_q + (tracking ? d_lu : '0);

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q     <= PAVC_ST_BOOT;
      base_q      <= '0;
      pos_q       <= '0;
      rem_q       <= '0;
      prev_raw_q  <= '0;
      prev_sel_q  <= ENC_SEL_RST;
      have_prev_q <= 1'b0;
      corr_prev_q <= 1'b0;
    end else begin
      corr_prev_q <= corr_act;
      prev_raw_q  <= raw_pos;
      prev_sel_q  <= sel_idx;
      have_prev_q <= raw_ok;
      if (set_position_request_in) begin
        state_q <= PAVC_ST_SET;
        base_q  <= position_setting_value_in - offs;
        pos_q   <= position_setting_value_in;
        rem_q   <= '0;
      end else begin
        case (state_q)
          // start as soon as encoder valid
          PAVC_ST_BOOT: begin
            if (raw_ok) state_q <= PAVC_ST_TRACK;
          end
          PAVC_ST_TRACK: begin
            if (tracking) rem_q <= rem_d;
          end
          PAVC_ST_SET: begin
            state_q <= raw_ok ? PAVC_ST_TRACK : PAVC_ST_BOOT;
          end
          default: state_q <= PAVC_ST_BOOT;
        endcase
        base_q <= base_d;
        pos_q  <= base_d + offs;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Velocity: length units per velocity window
  logic [VEL_CNT_W-1:0]    win_q;
  logic signed [POS_W-1:0] vel_ref_q;
  logic signed [POS_W-1:0] vel_q;
  logic                    valid_q;
  wire  win_tick = (win_q == VEL_CNT_W'(VEL_WIN - 1));

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      win_q     <= '0;
      vel_ref_q <= '0;
      vel_q     <= '0;
      valid_q   <= 1'b0;
    end else begin
      valid_q <= (state_q != PAVC_ST_BOOT);
      win_q   <= win_tick ? '0 : win_q + 1'b1;
      if (win_tick) begin
        vel_q     <= pos_q - vel_ref_q;
        vel_ref_q <= pos_q;
      end
    end
  end

  assign position_actual_value_out = pos_q;
  assign velocity_actual_value_out = vel_q;
  assign position_valid_out        = valid_q;
endmodule // pavc_core
`default_nettype wire

// >>> pavc_pkg.sv
// Package for position actual value conditioning constants and types
`default_nettype none
package pavc_pkg;
  localparam int POS_W        = 32;
  localparam int ENC_W        = 32;
  localparam int CTL_W        = 16;
  localparam int GEAR_W       = 16;
  localparam int NUM_ENC      = 3;
  localparam int SEL_W        = 2;
  // Time base for the velocity value, in microseconds, and its cycle count at 40 MHz
  localparam int CLK_MHZ      = 40;
  localparam int VEL_WIN_US   = 1000;
  localparam int VEL_WIN_CYC  = VEL_WIN_US * CLK_MHZ;
  localparam int VEL_CNT_W    = 16;
  // Linear scale reference travel in millimetres
  localparam int LIN_REF_MM   = 10;
  localparam int FINE_MAX     = 31;
  localparam logic [SEL_W-1:0] ENC_SEL_RST = 2'h0;
  typedef enum logic [1:0] {
    PAVC_ST_BOOT   = 2'b00,
    PAVC_ST_TRACK  = 2'b01,
    PAVC_ST_SET    = 2'b10
  } pavc_state_t;
endpackage
`default_nettype wire

// >>> pavc_core_assertions.sv
// Assertion checker for the position conditioning core
`default_nettype none
module pavc_core_assertions (
  input wire logic               mclk_in,
  input wire logic               rstn_in,
  input wire logic [95:0]        encoder_cyclic_position_in,
  input wire logic [2:0]         encoder_valid_in,
  input wire logic [1:0]         encoder_assignment_in,
  input wire logic [47:0]        generated_encoder_control_word_in,
  input wire logic               basic_positioner_active_in,
  input wire logic               correction_activate_in,
  input wire logic signed [31:0] correction_value_in,
  input wire logic signed [31:0] position_offset_input_in,
  input wire logic               set_position_request_in,
  input wire logic signed [31:0] position_setting_value_in,
  input wire logic [47:0]        encoder_control_input_out,
  input wire logic signed [31:0] position_actual_value_out,
  input wire logic signed [31:0] velocity_actual_value_out,
  input wire logic               position_valid_out
);
  logic [31:0]        enc_q;
  logic signed [31:0] off_q;
  logic               set_q, ca_q, bas_q;
  logic [1:0]         ch_q;
  wire                set = set_position_request_in;
  wire signed [31:0]  pos = position_actual_value_out;
  wire signed [31:0]  off = position_offset_input_in;
  wire [1:0]          ch = (encoder_assignment_in == 2'h3) ? 2'h0 : encoder_assignment_in;
  wire [31:0]         enc = encoder_cyclic_position_in[ch*32 +: 32];
  wire                rise = correction_activate_in & ~ca_q;
  // Calm: selected channel still, no set, positioner off, so only offset or correction move it
  wire calm = position_valid_out & ~set & ~set_q & ~basic_positioner_active_in & ~bas_q
              & (enc == enc_q) & (ch == ch_q);
  always_ff @(posedge mclk_in) begin
    {enc_q, off_q, set_q, ca_q, bas_q, ch_q} <=
      {enc, off, set, correction_activate_in, basic_positioner_active_in, ch};
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  property p_set; set && $past(rstn_in) |=> pos == $past(position_setting_value_in); endproperty
  a_set: assert property (p_set) else $error("set value not loaded");
  property p_hold; set ##1 (set && $stable(position_setting_value_in)) |=> $stable(pos); endproperty
  a_hold: assert property (p_hold) else $error("value moved while set");
  property p_ctl;
    $past(rstn_in) |-> encoder_control_input_out == $past(generated_encoder_control_word_in);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control word not routed");
  property p_corr; calm && rise && off == off_q |=> pos == $past(pos) + $past(correction_value_in);
  endproperty
  a_corr: assert property (p_corr) else $error("correction not applied");
  property p_off; calm && !rise && off != off_q |=> pos - $past(pos) == $past(off) - $past(off_q);
  endproperty
  a_off: assert property (p_off) else $error("offset not added");
  property p_still; calm && !rise && off == off_q |=> $stable(pos); endproperty
  a_still: assert property (p_still) else $error("position drifts");
  property p_vel; $changed(velocity_actual_value_out) |=> $stable(velocity_actual_value_out)[*7];
  endproperty
  a_vel: assert property (p_vel) else $error("velocity not held a window");
  property p_valid;
    encoder_valid_in[0] && encoder_assignment_in == 2'h0 |-> ##[0:3] position_valid_out;
  endproperty
  a_valid: assert property (p_valid) else $error("no conditioning after valid");
  c_set: cover property (set ##1 !set);
  c_corr: cover property (calm && rise);
  c_vel: cover property ($changed(velocity_actual_value_out));
endmodule // pavc_core_assertions
bind pavc_core pavc_core_assertions u_chk (.*);
`default_nettype wire

// >>> pavc_enc_model.sv
// Behavioural model of three encoder evaluation channels
`default_nettype none
module pavc_enc_model #(
  parameter int LAT = 5
) (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic [2:0]  run_in,
  output logic      [95:0] pos_out,
  output logic      [2:0]  valid_out
);
  int n;
  // Valid only LAT cycles after boot, so the core must wait for it
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      n <= 0;
      pos_out <= '0;
    end else begin
      n <= (n < LAT) ? n + 1 : n;
      // Channel k moves 4*(k+1) counts a cycle, so a wrong pick shows
      for (int k = 0; k < 3; k++) begin
        if (run_in[k]) pos_out[k*32 +: 32] <= pos_out[k*32 +: 32] + 32'(4 * (k + 1));
      end
    end
  end
  assign valid_out = {3{n >= LAT}};
endmodule // pavc_enc_model
`default_nettype wire

// >>> position_actual_value_conditioning_tb_top.sv
// Self-checking bench for the position conditioning core
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module position_actual_value_conditioning_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 0, rstn_in = 0, encoder_linear_in = 0, measuring_gear_type_in = 0;
  logic basic_positioner_active_in = 0, correction_activate_in = 0, set_position_request_in = 0;
  logic positioner_correction_activate_in = 0;
  logic [1:0] encoder_assignment_in = '0;
  logic [4:0] fine_resolution_bits_in = 5'h1;
  logic [15:0] encoder_pulses_per_rev_in = 16'h2, measuring_gear_load_revs_in = 16'h2;
  logic [15:0] measuring_gear_encoder_revs_in = 16'h1, motor_revolutions_in = 16'h1;
  logic signed [15:0] load_revolutions_in = 16'sh1;
  logic [31:0] length_units_per_load_rev_in = 32'h64, length_units_per_10mm_in = 32'h3e8;
  logic [31:0] encoder_counts_per_10mm_in = 32'h28;
  logic signed [31:0] correction_value_in = '0, positioner_correction_value_in = '0, p0;
  logic signed [31:0] position_offset_input_in = '0, positioner_backlash_offset_in = '0;
  logic signed [31:0] position_setting_value_in = '0, position_actual_value_out;
  logic signed [31:0] velocity_actual_value_out;
  logic [47:0] generated_encoder_control_word_in = '0, encoder_control_input_out;
  logic [95:0] encoder_cyclic_position_in;
  logic [2:0] encoder_valid_in, run = '0;
  logic position_valid_out;
  int num_errors = 0, num_checks = 0;
  always #12.5 mclk_in = ~mclk_in;
  // Short velocity window keeps the run brief
  pavc_core #(.VEL_WIN(8)) DUT (.*);
  pavc_enc_model #(.LAT(5)) u_enc (.mclk_in, .rstn_in, .run_in(run),
    .pos_out(encoder_cyclic_position_in), .valid_out(encoder_valid_in));
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic move(input int n, input logic signed [31:0] e);
    p0 = position_actual_value_out;
    run = 3'h7;
    cyc(n);
    run = '0;
    cyc(4);
    `CHK(position_actual_value_out, p0 + e)
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_scale;
    move(5, 32'sh1f4);
    load_revolutions_in = -16'sh1;
    move(5, -32'sh1f4);
    measuring_gear_type_in = 1;
    move(5, -32'shfa);
    {load_revolutions_in, measuring_gear_type_in} = {16'sh1, 1'b0};
    run = 3'h7;
    cyc(20);
    `CHK(velocity_actual_value_out, 32'sh320)
    run = '0;
    cyc(4);
  endtask
  task automatic t_select;
    encoder_linear_in = 1;
    for (int k = 0; k < 4; k++) begin
      encoder_assignment_in = 2'(k);
      cyc(4);
      move(5, 32'sh1f4 * (k % 3 + 1));
    end
    {encoder_assignment_in, encoder_linear_in} = 3'h0;
    generated_encoder_control_word_in = 48'h1234_5678_9abc;
    cyc(2);
    `CHK(encoder_control_input_out, 48'h1234_5678_9abc)
  endtask
  task automatic t_set;
    position_setting_value_in = 32'sh1234;
    {set_position_request_in, run} = 4'hf;
    cyc(3);
    `CHK(position_actual_value_out, 32'sh1234)
    {set_position_request_in, run} = 4'h0;
    cyc(3);
    `CHK(position_actual_value_out, 32'sh1234)
  endtask
  task automatic t_corr;
    p0 = position_actual_value_out;
    correction_value_in = -32'sh7;
    position_offset_input_in = 32'sh9;
    repeat (2) begin
      correction_activate_in = 1;
      cyc(1);
      correction_activate_in = 0;
      cyc(1);
    end
    {basic_positioner_active_in, positioner_correction_activate_in, correction_activate_in} = 3'h7;
    positioner_correction_value_in = 32'sh5;
    positioner_backlash_offset_in = 32'sh1e;
    cyc(3);
    `CHK(position_actual_value_out, p0 - 14 + 5 + 30)
  endtask
  initial begin
    cyc(12);
    rstn_in = 1;
    for (int i = 0; i < 50 && position_valid_out !== 1'b1; i++) cyc(1);
    `CHK(position_valid_out, 1'b1)
    if (position_valid_out !== 1'b1) finish_test();
    t_scale();
    t_select();
    t_set();
    t_corr();
    finish_test();
  end
endmodule // position_actual_value_conditioning_tb_top
`default_nettype wire
